/* File: dmc_cfg.svh */
`ifndef DMC_CFG_SVH
`define DMC_CFG_SVH
// clock period in ns
`define DMC_CLK_NS 10
// timing figures in ns, refresh period in ms
`define DMC_T_PRE_NS 125
`define DMC_T_RCD_MIN_NS 90
`define DMC_T_CYC_NS 425
`define DMC_T_CYC_RMW_NS 595
`define DMC_T_CAS_NS 200
`define DMC_T_RAS_NS 300
`define DMC_T_CAS_RMW_NS 320
`define DMC_T_RAS_RMW_NS 450
`define DMC_T_WR_NS 200
`define DMC_T_CAS_RAS_NS 200
`define DMC_T_REF_MS 2
// cycle counts, least times rounded up
`define DMC_CYC(ns) (((ns) + `DMC_CLK_NS - 1) / `DMC_CLK_NS)
`define DMC_N_PRE `DMC_CYC(`DMC_T_PRE_NS)
`define DMC_N_RCD `DMC_CYC(`DMC_T_RCD_MIN_NS)
`define DMC_N_CYC `DMC_CYC(`DMC_T_CYC_NS)
`define DMC_N_CYC_RMW `DMC_CYC(`DMC_T_CYC_RMW_NS)
`define DMC_N_CAS `DMC_CYC(`DMC_T_CAS_NS)
`define DMC_N_RAS `DMC_CYC(`DMC_T_RAS_NS)
`define DMC_N_CAS_RMW `DMC_CYC(`DMC_T_CAS_RMW_NS)
`define DMC_N_RAS_RMW `DMC_CYC(`DMC_T_RAS_RMW_NS)
`define DMC_N_WR `DMC_CYC(`DMC_T_WR_NS)
`define DMC_N_CAS_RAS `DMC_CYC(`DMC_T_CAS_RAS_NS)
// 2 ms refresh period in cycles, longest time rounded down
`define DMC_N_REF_DEF ((`DMC_T_REF_MS * 1000000) / `DMC_CLK_NS)
// cycles kept back for an access that delays a due refresh
`define DMC_N_REF_SLACK 128
`define DMC_ROWS 64
`define DMC_ROW_W 6
`define DMC_CNT_W 8
`endif

/* File: dmc_ctrl.sv */
`timescale 1ns/1ns
`include "dmc_cfg.svh"
// Operation
// - refresh every row within 2 ms
// - row strobe high 125 ns between cycles
// - row to column strobe 90..2000 ns
// - read cycle lasts at least 425 ns
// - write cycle lasts at least 425 ns
// - read-modify-write cycle lasts at least 595 ns
// - column strobe low 200..10000 ns
// - row strobe low 300..32000 ns
// - rmw stretches strobes to 320/450 ns
// - write line low at least 200 ns
// - row low 200 ns after column falls
// - column low 300 ns after row falls
// - refresh walks all 64 row addresses
module dmc_ctrl
  import dmc_pkg::*;
#(
  parameter int REF_CYCLES = (`DMC_N_REF_DEF - `DMC_N_REF_SLACK) / `DMC_ROWS
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // user request port
  input wire logic req_valid,
  input wire dmc_req_s req,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_data,
  // memory pins
  output dmc_pins_s pins,
  input wire logic dout
);

  typedef enum logic [5:0] {
    ST_IDLE = 6'b00_0001,
    ST_ROW = 6'b00_0010,
    ST_COL = 6'b00_0100,
    ST_WRW = 6'b00_1000,
    ST_END = 6'b01_0000,
    ST_PRE = 6'b10_0000
  } dmc_st_e;

  localparam logic [7:0] N_RCD = 8'(`DMC_N_RCD);
  localparam logic [7:0] N_PRE = 8'(`DMC_N_PRE);
  localparam logic [7:0] N_CAS = 8'(`DMC_N_CAS);
  localparam logic [7:0] N_RAS = 8'(`DMC_N_RAS);
  localparam logic [7:0] N_CAS_RMW = 8'(`DMC_N_CAS_RMW);
  localparam logic [7:0] N_RAS_RMW = 8'(`DMC_N_RAS_RMW);
  localparam logic [7:0] N_WR = 8'(`DMC_N_WR);
  localparam logic [7:0] N_CR = 8'(`DMC_N_CAS_RAS);
  localparam logic [7:0] N_CYC = 8'(`DMC_N_CYC);
  localparam logic [7:0] N_CYC_RMW = 8'(`DMC_N_CYC_RMW);

  dmc_st_e state_reg;
  logic [7:0] cnt_reg; // cycles in current state
  logic [7:0] cyc_reg; // cycles since row strobe fell
  logic [15:0] ref_cnt_reg;
  logic ref_due_reg;
  logic [5:0] ref_row_reg;
  logic is_ref_reg;
  dmc_req_s cur_reg;
  logic [7:0] ras_need;
  logic [7:0] cyc_need;
  logic [7:0] cas_need;
  logic end_done; // row strobe may rise, cycle may close

  // hold times depend on the cycle kind; refresh keeps the plain widths
  // so a row-only cycle still holds the row strobe for its minimum
  always_comb begin
    ras_need = (cur_reg.op == DMC_OP_RMW) ? N_RAS_RMW : N_RAS;
    cas_need = (cur_reg.op == DMC_OP_RMW) ? N_CAS_RMW : N_CAS;
    cyc_need = (cur_reg.op == DMC_OP_RMW) ? N_CYC_RMW : N_CYC;
    if (is_ref_reg) begin
      ras_need = N_RAS;
      cyc_need = N_CYC;
    end
    // the row strobe stays low until column hold and width are met
    end_done = cnt_reg >= N_CR - 8'h01 && cyc_reg >= ras_need - 8'h01;
  end

  // refresh interval timer
  // a flag raised during a long cycle waits for the next idle state
  // when the wrap and the clear meet, the new request wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt_reg <= 16'h0000;
      ref_due_reg <= 1'b0;
    end else begin
      if (ref_cnt_reg == 16'(REF_CYCLES - 1)) begin
        ref_cnt_reg <= 16'h0000;
        ref_due_reg <= 1'b1;
      end else begin
        ref_cnt_reg <= ref_cnt_reg + 16'h0001;
        if (state_reg == ST_IDLE && ref_due_reg)
          ref_due_reg <= 1'b0;
      end
    end
  end

  // cycle sequencer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      cyc_reg <= 8'h00;
      is_ref_reg <= 1'b0;
      cur_reg <= '0;
      ref_row_reg <= 6'h00;
    end else begin
      cnt_reg <= cnt_reg + 8'h01;
      cyc_reg <= cyc_reg + 8'h01;
      case (state_reg)
        ST_IDLE: begin
          cnt_reg <= 8'h00;
          cyc_reg <= 8'h00;
          if (ref_due_reg) begin
            is_ref_reg <= 1'b1;
            cur_reg <= '0;
            cur_reg.addr <= {6'h00, ref_row_reg};
            ref_row_reg <= ref_row_reg + 6'h01;
            state_reg <= ST_ROW;
          end else if (req_valid) begin
            is_ref_reg <= 1'b0;
            cur_reg <= req;
            state_reg <= ST_ROW;
          end
        end
        ST_ROW: begin
          if (cnt_reg == N_RCD - 8'h01) begin
            cnt_reg <= 8'h00;
            state_reg <= is_ref_reg ? ST_END : ST_COL;
          end
        end
        ST_COL: begin
          // read data sampled after column access time
          if (cnt_reg == cas_need - 8'h01) begin
            cnt_reg <= 8'h00;
            state_reg <= (cur_reg.op == DMC_OP_RMW) ? ST_WRW : ST_END;
          end
        end
        ST_WRW: begin
          // write phase right after read data, zero modify time
          if (cnt_reg == N_WR - 8'h01) begin
            cnt_reg <= 8'h00;
            state_reg <= ST_END;
          end
        end
        ST_END: begin
          // row stays low past column hold and minimum width
          if (end_done) begin
            cnt_reg <= 8'h00;
            state_reg <= ST_PRE;
          end
        end
        ST_PRE: begin
          // precharge and cycle time are both counted here
          if (cnt_reg >= N_PRE - 8'h01 && cyc_reg >= cyc_need - 8'h01) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // pin drive from state
  // strobes come from flip-flops so the device sees clean edges
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins <= '{ras_n: 1'b1, cas_n: 1'b1, cs_n: 1'b1, wr_n: 1'b1,
                addr: 6'h00, din: 1'b0};
    end else begin
      pins.ras_n <= !(state_reg inside {ST_ROW, ST_COL, ST_WRW} ||
                      (state_reg == ST_END && !end_done) ||
                      (state_reg == ST_IDLE && (ref_due_reg || req_valid)));
      pins.cas_n <= !(state_reg inside {ST_COL, ST_WRW}) &&
                    !(state_reg == ST_ROW && !is_ref_reg &&
                      cnt_reg == N_RCD - 8'h01);
      // deselected during refresh, so the output latch is left alone
      pins.cs_n <= is_ref_reg || state_reg inside {ST_IDLE, ST_PRE};
      pins.wr_n <= !((state_reg inside {ST_ROW, ST_COL} &&
                      cur_reg.op == DMC_OP_WRITE && !is_ref_reg) ||
                     (state_reg == ST_COL && cur_reg.op == DMC_OP_RMW &&
                      cnt_reg == cas_need - 8'h01) ||
                     (state_reg == ST_WRW && cnt_reg != N_WR - 8'h01));
      if (state_reg == ST_IDLE)
        pins.addr <= ref_due_reg ? ref_row_reg : req.addr[5:0];
      else if (state_reg == ST_ROW && cnt_reg == N_RCD - 8'h01)
        pins.addr <= cur_reg.addr[11:6];
      pins.din <= cur_reg.wdata;
    end
  end

  // handshake and read data capture
  // refresh has priority, so a request may wait in the idle state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 1'b0;
    end else begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      if (state_reg == ST_IDLE && !ref_due_reg && req_valid)
        req_ready <= 1'b1;
      // latched device output sampled at end of column access
      if (state_reg == ST_COL && cnt_reg == cas_need - 8'h01 &&
          cur_reg.op != DMC_OP_WRITE) begin
        rsp_valid <= 1'b1;
        rsp_data <= dout;
      end
    end
  end

endmodule // dmc_ctrl

/* File: dmc_ctrl_chk.sv */
`timescale 1ns/1ns
module dmc_ctrl_chk
  import dmc_pkg::*;
#(parameter int REF_CYCLES = 20) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // user side
  input wire logic req_valid,
  input wire dmc_req_s req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic rsp_data,
  // memory side
  input wire dmc_pins_s pins,
  input wire logic dout
);
  logic [7:0] rl_reg, rh_reg, cl_reg, gap_reg;
  logic rmw_reg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // saturating strobe width and spacing counters
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rl_reg <= 8'h00;
      rh_reg <= 8'hff;
      cl_reg <= 8'h00;
      gap_reg <= 8'hff;
    end else begin
      rl_reg <= pins.ras_n ? 8'h00 : rl_reg + 8'(rl_reg != 8'hff);
      rh_reg <= !pins.ras_n ? 8'h00 : rh_reg + 8'(rh_reg != 8'hff);
      cl_reg <= pins.cas_n ? 8'h00 : cl_reg + 8'(cl_reg != 8'hff);
      gap_reg <= $fell(pins.ras_n) ? 8'h01 : gap_reg + 8'(gap_reg != 8'hff);
    end
  end
  // late write strobe inside the column phase marks a rmw cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) rmw_reg <= 1'b0;
    else if ($fell(pins.ras_n)) rmw_reg <= 1'b0;
    else if ($fell(pins.wr_n) && !pins.cas_n) rmw_reg <= 1'b1;
  end
  // a strobe held low for 200 ns
  sequence low20(s);
    !s [*8] ##1 !s [*8] ##1 !s [*4];
  endsequence
  pre_width_a: assert property ($fell(pins.ras_n) |-> rh_reg >= 13)
    else $error("precharge short");
  rcd_window_a: assert property (
    $fell(pins.cas_n) |-> rl_reg inside {[9:200]})
    else $error("row to column delay");
  cycle_time_a: assert property (
    $fell(pins.ras_n) |-> gap_reg >= (rmw_reg ? 60 : 43))
    else $error("cycle short");
  cas_width_a: assert property ($rose(pins.cas_n) |-> cl_reg >= 20)
    else $error("column strobe short");
  cas_hold_a: assert property (
    $rose(pins.cas_n) |-> rl_reg >= 30)
    else $error("column hold short");
  // every row strobe, refresh included, meets its low width
  ras_width_a: assert property (
    $rose(pins.ras_n) |-> rl_reg >= (rmw_reg ? 45 : 30))
    else $error("row strobe short");
  rmw_width_a: assert property (
    $rose(pins.cas_n) && rmw_reg |-> cl_reg >= 32)
    else $error("rmw column short");
  wr_width_a: assert property (
    $fell(pins.wr_n) |-> low20(pins.wr_n))
    else $error("write pulse short");
  ras_hold_a: assert property (
    $fell(pins.cas_n) |-> low20(pins.ras_n))
    else $error("row hold short");
endmodule // dmc_ctrl_chk
bind dmc_ctrl dmc_ctrl_chk #(.REF_CYCLES(REF_CYCLES)) chk (.ref_clk, .rst_n,
  .req_valid, .req, .req_ready, .rsp_valid, .rsp_data, .pins, .dout);

/* File: dmc_ctrl_tb.sv */
`timescale 1ns/1ns
module dmc_ctrl_tb
  import dmc_pkg::*;
();
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  dmc_req_s req = '0;
  logic req_ready, rsp_valid, rsp_data, dout, q;
  dmc_pins_s pins;
  int errors = 0;
  int n_compared = 0;
  // clock
  always #5 ref_clk = ~ref_clk;
  // refresh spacing leaves room for a refresh plus the longest access
  dmc_ctrl #(.REF_CYCLES(150)) dut (.ref_clk, .rst_n, .req_valid, .req,
    .req_ready, .rsp_valid, .rsp_data, .pins, .dout);
  dmc_mem #(.T_REF_NS(100000)) mem (.pins, .dout);
  task automatic summarize();
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t data mismatch", $time);
    end
  endtask
  // bounded wait for accept or read data
  task automatic wait_sig(input bit rsp);
    int n;
    for (n = 0; n < 300 && (rsp ? rsp_valid : req_ready) !== 1'b1; n++)
      @(posedge ref_clk) #1;
    if (n == 300) begin
      errors++;
      $display("FAIL %0t timeout", $time);
      summarize();
    end
  endtask
  // one request held until accepted
  task automatic access(input dmc_op_e op, input logic [11:0] a,
                        input logic d);
    @(posedge ref_clk) #1;
    req <= '{op: op, addr: a, wdata: d};
    req_valid <= 1'b1;
    wait_sig(1'b0);
    req_valid <= 1'b0;
    if (op != DMC_OP_WRITE) wait_sig(1'b1);
    q = rsp_data;
  endtask
  // back-to-back writes and reads at address corners
  task automatic t_corners();
    logic [11:0] a [4] = '{12'h000, 12'hfff, 12'h03f, 12'hfc0};
    foreach (a[i]) access(DMC_OP_WRITE, a[i], i[0]);
    foreach (a[i]) begin
      access(DMC_OP_READ, a[i], 1'b0);
      check(q, i[0]);
    end
  endtask
  // rmw returns the old bit and stores the new one
  task automatic t_rmw();
    access(DMC_OP_RMW, 12'hfff, 1'b0);
    check(q, 1'b1);
    access(DMC_OP_READ, 12'hfff, 1'b1);
    check(q, 1'b0);
  endtask
  // bits survive a long idle spell only if every row is refreshed
  task automatic t_retain();
    // idle spell longer than the retention window of the model
    repeat (11000) @(posedge ref_clk);
    access(DMC_OP_READ, 12'h03f, 1'b1);
    check(q, 1'b0);
    access(DMC_OP_READ, 12'hfc0, 1'b0);
    check(q, 1'b1);
  endtask
  // reset then scenarios
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    t_corners();
    t_rmw();
    t_retain();
    summarize();
  end
endmodule // dmc_ctrl_tb

/* File: dmc_mem.sv */
`timescale 1ns/1ns
module dmc_mem
  import dmc_pkg::*;
// retention window scaled for sim: 64 rows at 150 cycles plus one access
#(parameter int T_REF_NS = 100000) (
  // controller pins
  input wire dmc_pins_s pins,
  // read data
  output logic dout
);
  logic mem [4096];
  time seen [64];
  logic [5:0] row, col;
  initial begin
    dout = 1'b0;
    foreach (seen[i]) seen[i] = 0;
    foreach (mem[i]) mem[i] = 1'b0;
  end
  // each row strobe refreshes its row; a stale row loses its bits
  always @(negedge pins.ras_n) begin
    row = pins.addr;
    if ($time - seen[row] > T_REF_NS)
      for (int c = 0; c < 64; c++) mem[{c[5:0], row}] = ~mem[{c[5:0], row}];
    seen[row] = $time;
  end
  // column strobe: early write, or read after the access time
  always @(negedge pins.cas_n) begin
    col = pins.addr;
    if (!pins.cs_n && !pins.wr_n) mem[{col, row}] = pins.din;
    else if (!pins.cs_n) begin
      dout = ~dout; // invalid until access time
      #195 dout = mem[{col, row}]; // held to next cycle
    end
  end
  // late write strobe of a rmw cycle
  always @(negedge pins.wr_n) begin
    if (!pins.cas_n && !pins.cs_n) mem[{col, row}] = pins.din;
  end
endmodule // dmc_mem

/* File: dmc_pkg.sv */
package dmc_pkg;
  // controller cycle kinds
  typedef enum logic [1:0] {
    DMC_OP_READ = 2'h0,
    DMC_OP_WRITE = 2'h1,
    DMC_OP_RMW = 2'h2
  } dmc_op_e;
  // one user request
  typedef struct packed {
    dmc_op_e op;
    logic [11:0] addr;
    logic wdata;
  } dmc_req_s;
  // memory pin group driven by the controller
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic cs_n;
    logic wr_n;
    logic [5:0] addr;
    logic din;
  } dmc_pins_s;
endpackage
